/* hw/serial_port_dma_channel.sv */
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
module serial_port_dma_channel
  import dma_chan_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rstn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output      logic [31:0]                prdata,
  output      logic                       pready,
  output      logic                       pslverr,
  // Serial port requests
  input  wire logic [1:0]                 rxFullFlag,
  input  wire logic [1:0]                 txEmptyFlag,
  // Serial port data registers
  input  wire logic [1:0][23:0]           rxData,
  output      logic [1:0]                 rxRead,
  output      logic [1:0]                 txWrite,
  output      logic [23:0]                txData,
  // Arbitration and interrupt
  output      logic [1:0]                 channelPriority,
  output      logic                       irq
);
  import dma_chan_pkg::*;

  typedef struct packed {
    logic [23:0] ctrl;
    logic [23:0] src;
    logic [23:0] dst;
    logic [23:0] cnt;
    logic [1:0]  status;
    logic [1:0]  mask;
    dma_state_t  state;
    logic        portRx;
    logic        portIdx;
    logic        reqSeen;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  rxRead;
    logic [1:0]  txWrite;
    logic [23:0] txData;
    logic        irq;
  } chan_state_t;

  chan_state_t s_q, s_d;
  mem_req_t    memReq;
  logic [23:0] memRdata;
  logic [4:0]  reqSel;
  logic        reqLine;
  logic        reqIsRx;
  logic        reqIdx;
  logic        reqValid;
  logic        apbAcc;

  assign reqSel = s_q.ctrl[REQ_LO +: 5];
  assign apbAcc = psel && penable && !s_q.pready;

  ////////////////////////////////////////////////////////////////////
  // Request source decode

  always_comb begin
    reqValid = 1'b1;
    reqIsRx  = 1'b0;
    reqIdx   = 1'b0;
    if (reqSel == REQ_P0_RX) begin
      reqIsRx = 1'b1;
    end else if (reqSel == REQ_P0_TX) begin
      reqIsRx = 1'b0;
    end else if (reqSel == REQ_P1_RX) begin
      reqIsRx = 1'b1;
      reqIdx  = 1'b1;
    end else if (reqSel == REQ_P1_TX) begin
      reqIdx  = 1'b1;
    end else begin
      reqValid = 1'b0;
    end
    reqLine = reqValid &&
              (reqIsRx ? rxFullFlag[reqIdx] : txEmptyFlag[reqIdx]);
  end

  ////////////////////////////////////////////////////////////////////
  // Memory access: rx path writes dst, tx path reads src

  always_comb begin
    memReq       = '0;
    // Rx: port word lands in rdata on READ, goes to memory on WRITE
    memReq.we    = s_q.portRx && (s_q.state == WRITE);
    memReq.space = s_q.portRx ? s_q.ctrl[DSP_LO +: 2]
                              : s_q.ctrl[SSP_LO +: 2];
    memReq.addr  = s_q.portRx ? s_q.dst : s_q.src;
    memReq.wdata = memRdata;
    memReq.req   = s_q.portRx ? (s_q.state == WRITE)
                              : (s_q.state == READ);
  end

  dma_word_store #(
    .AW (AW),
    .DW (24)
  ) u_store (
    .clk     (clk),
    .en      (memReq.req),
    .we      (memReq.we),
    .space   (memReq.space == SPACE_Y),
    .addr    (memReq.addr[AW-1:0]),
    .wdata   (memReq.wdata),
    .extData (rxData[s_q.portIdx]),
    .rdata   (memRdata)
  );

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [2:0] address_mode_field;
    logic [2:0] sam;
    logic       last;
    logic [1:0] evt;
    s_d         = s_q;
    address_mode_field         = s_q.ctrl[DAM_LO +: 3];
    sam         = s_q.ctrl[SAM_LO +: 3];
    last        = (s_q.cnt == CNT_RST);
    evt         = 2'h0;
    s_d.rxRead  = 2'h0;
    s_d.txWrite = 2'h0;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    if (!reqLine) begin
      s_d.reqSeen = 1'b0;
    end

    case (s_q.state)
      IDLE: begin
        // Edge on request: the port drops it only after our access lands
        if (s_q.ctrl[EN_BIT] && reqLine && !s_q.reqSeen) begin
          s_d.portRx  = reqIsRx;
          s_d.portIdx = reqIdx;
          s_d.reqSeen = 1'b1;
          s_d.state   = READ;
        end
      end
      READ: begin
        // Rx: receive word captured into rdata; tx: memory word read
        if (s_q.portRx) begin
          s_d.rxRead[s_q.portIdx] = 1'b1;
        end
        s_d.state = WRITE;
      end
      WRITE: begin
        // Rx leaves txData alone: it stands until the next tx word
        if (!s_q.portRx) begin
          s_d.txData = memRdata;
          s_d.txWrite[s_q.portIdx] = 1'b1;
        end
        if (address_mode_field == AM_INC) begin
          s_d.dst = s_q.dst + 24'h000001;
        end
        if (sam == AM_INC) begin
          s_d.src = s_q.src + 24'h000001;
        end
        evt[ST_XFER] = 1'b1;
        if (last) begin
          if (!s_q.ctrl[CONT_BIT]) begin
            s_d.ctrl[EN_BIT] = 1'b0;
          end
          evt[ST_DONE] = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 24'h000001;
        end
        s_d.state = IDLE;
      end
      default: s_d.state = IDLE;
    endcase
    // Events kept apart so a read clear cannot eat one
    s_d.status = s_q.status | evt;

    // APB: one wait state, answer on the cycle after the access phase
    if (apbAcc) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h00000000;
      if (paddr == CTRL_OFS) begin
        s_d.prdata = {8'h00, s_q.ctrl};
        if (pwrite) s_d.ctrl = pwdata[23:0];
      end else if (paddr == SRC_OFS) begin
        s_d.prdata = {8'h00, s_q.src};
        if (pwrite) s_d.src = pwdata[23:0];
      end else if (paddr == DST_OFS) begin
        s_d.prdata = {8'h00, s_q.dst};
        if (pwrite) s_d.dst = pwdata[23:0];
      end else if (paddr == CNT_OFS) begin
        s_d.prdata = {8'h00, s_q.cnt};
        if (pwrite) s_d.cnt = pwdata[23:0];
      end else if (paddr == STATUS_OFS) begin
        s_d.prdata = {30'h0, s_q.status};
        // Read clears, but a same-cycle event still sets
        if (!pwrite) s_d.status = evt;
      end else if (paddr == MASK_OFS) begin
        s_d.prdata = {30'h0, s_q.mask};
        if (pwrite) s_d.mask = pwdata[1:0];
      end else begin
        s_d.pslverr = 1'b1;
      end
    end

    // Done source needs the control interrupt enable too
    s_d.irq = |(s_d.status & s_d.mask &
                {1'b1, s_d.ctrl[IRQEN_BIT]});
    if (!rstn) begin
      s_d         = '0;
      s_d.ctrl    = CTRL_RST;
      s_d.src     = ADDR_RST;
      s_d.dst     = ADDR_RST;
      s_d.cnt     = CNT_RST;
      s_d.status  = STAT_RST;
      s_d.state   = IDLE;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign prdata          = s_q.prdata;
  assign pready          = s_q.pready;
  assign pslverr         = s_q.pslverr;
  assign rxRead          = s_q.rxRead;
  assign txWrite         = s_q.txWrite;
  assign txData          = s_q.txData;
  assign channelPriority = s_q.ctrl[PRI_LO +: 2];
  assign irq             = s_q.irq;

  ////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_start;
    s_q.state == IDLE && s_d.state == READ;
  endsequence

  property p_walk;
    @(posedge clk) disable iff (!rstn)
      s_start |=> (s_q.state == READ) ##1 (s_q.state == WRITE)
              ##1 (s_q.state == IDLE);
  endproperty

  a_xfer_walk: assert property (p_walk)
    else $error("transfer sequence broken");

  a_no_start_off: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.state == IDLE && !s_q.ctrl[EN_BIT]) |=> s_q.state == IDLE)
    else $error("started while disabled");

  a_cnt_decr: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.state == WRITE && s_q.cnt != 24'h0 && !apbAcc)
      |=> s_q.cnt == $past(s_q.cnt) - 24'h000001)
    else $error("counter not decremented");

  a_self_off: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.state == WRITE && s_q.cnt == 24'h0 && !s_q.ctrl[CONT_BIT]
     && !apbAcc) |=> !s_q.ctrl[EN_BIT])
    else $error("channel not disabled at end");

  a_dst_inc: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.state == WRITE && s_q.ctrl[DAM_LO +: 3] == AM_INC && !apbAcc)
      |=> s_q.dst == $past(s_q.dst) + 24'h000001)
    else $error("destination not incremented");

  a_src_hold: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.state == WRITE && s_q.ctrl[SAM_LO +: 3] == AM_HOLD && !apbAcc)
      |=> $stable(s_q.src))
    else $error("source moved in hold mode");

  a_tx_write: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.state == WRITE && !s_q.portRx) |=> txWrite[$past(s_q.portIdx)])
    else $error("transmit write missing");

  a_src_decode: assert property (@(posedge clk) disable iff (!rstn)
    (s_start and (reqSel == REQ_P1_RX)) |=> (s_q.portRx && s_q.portIdx))
    else $error("request source decode wrong");

  a_prio_field: assert property (@(posedge clk) disable iff (!rstn)
    (apbAcc && pwrite && paddr == CTRL_OFS)
      |=> channelPriority == $past(pwdata[PRI_LO +: 2]))
    else $error("priority field not taken");

endmodule : serial_port_dma_channel

/* hw/dma_chan_pkg.sv */
package dma_chan_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] SRC_OFS     = 8'h04;
  localparam logic [7:0] DST_OFS     = 8'h08;
  localparam logic [7:0] CNT_OFS     = 8'h0c;
  localparam logic [7:0] STATUS_OFS  = 8'h10;
  localparam logic [7:0] MASK_OFS    = 8'h14;

  // Control field positions
  localparam int EN_BIT    = 23;
  localparam int IRQEN_BIT = 22;
  localparam int TM_LO     = 19;
  localparam int PRI_LO    = 17;
  localparam int CONT_BIT  = 16;
  localparam int REQ_LO    = 11;
  localparam int THREED_BIT = 10;
  localparam int DAM_LO    = 7;
  localparam int SAM_LO    = 4;
  localparam int DSP_LO    = 2;
  localparam int SSP_LO    = 0;

  // Reset values
  localparam logic [23:0] CTRL_RST = 24'h000000;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  localparam logic [23:0] CNT_RST  = 24'h000000;
  localparam logic [1:0]  STAT_RST = 2'h0;

  // Request source codes
  localparam logic [4:0] REQ_P0_RX = 5'h0a;
  localparam logic [4:0] REQ_P0_TX = 5'h0b;
  localparam logic [4:0] REQ_P1_RX = 5'h0c;
  localparam logic [4:0] REQ_P1_TX = 5'h0d;

  // Address update modes
  localparam logic [2:0] AM_HOLD = 3'h4;
  localparam logic [2:0] AM_INC  = 3'h5;

  // Memory spaces
  localparam logic [1:0] SPACE_X = 2'h0;
  localparam logic [1:0] SPACE_Y = 2'h1;

  // Status bits
  localparam int ST_DONE = 0;
  localparam int ST_XFER = 1;

  typedef enum logic [1:0] {
    IDLE,
    READ,
    WRITE
  } dma_state_t;

  // One memory-side access, carried to the store
  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  space;
    logic [23:0] addr;
    logic [23:0] wdata;
  } mem_req_t;

endpackage : dma_chan_pkg

/* hw/dma_word_store.sv */
`timescale 1ns/1ps
module dma_word_store #(
  parameter int AW = 8,
  parameter int DW = 24
) (
  // Clock
  input  wire logic          clk,
  // Access
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic          space,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [DW-1:0] extData,
  output      logic [DW-1:0] rdata
);

  // Two banks: X and Y memory, selected by space
  logic [DW-1:0] memX [2**AW];
  logic [DW-1:0] memY [2**AW];

  always_ff @(posedge clk) begin
    if (en && we) begin
      if (space) begin
        memY[addr] <= wdata;
      end else begin
        memX[addr] <= wdata;
      end
    end
    if (en && !we) begin
      rdata <= space ? memY[addr] : memX[addr];
    end else begin
      rdata <= extData;
    end
  end

endmodule : dma_word_store

/* dv/serial_port_model.sv */
`timescale 1ns/1ps
module serial_port_model (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Bench commands
  input  wire logic [1:0]       loadRx,
  input  wire logic [23:0]      loadWord,
  input  wire logic [1:0]       shiftTx,
  // Channel side
  input  wire logic [1:0]       rxRead,
  input  wire logic [1:0]       txWrite,
  output      logic [1:0]       rxFullFlag,
  output      logic [1:0]       txEmptyFlag,
  output      logic [1:0][23:0] rxData
);
  logic [1:0][23:0] rxWord_q;
  // Stale word inverted so a late read cannot pass
  always_comb begin
    for (int i = 0; i < 2; i++)
      rxData[i] = rxFullFlag[i] ? rxWord_q[i] : ~rxWord_q[i];
  end
  // Transmitter starts disabled, so no request until a shift
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rxFullFlag <= 2'h0;
      txEmptyFlag <= 2'h0;
      rxWord_q <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (loadRx[i]) begin
          rxFullFlag[i] <= 1'b1;
          rxWord_q[i] <= loadWord;
        end else if (rxRead[i]) rxFullFlag[i] <= 1'b0;
        if (txWrite[i]) txEmptyFlag[i] <= 1'b0;
        else if (shiftTx[i]) txEmptyFlag[i] <= 1'b1;
      end
    end
  end
endmodule : serial_port_model

/* dv/serial_port_dma_channel_test.sv */
`timescale 1ns/1ps
module serial_port_dma_channel_test;
  import dma_chan_pkg::*;
  logic             clk, rstn, psel, penable, pwrite;
  logic             pready, pslverr, irq, perr;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rdat;
  logic [1:0]       rxFullFlag, txEmptyFlag, rxRead, txWrite;
  logic [1:0]       channelPriority, loadRx, shiftTx;
  logic [23:0]      loadWord, txData;
  logic [1:0][23:0] rxData;
  int               fails, num_checks;
  //////////////////////////////////////////////////////////////////////
  serial_port_dma_channel #(.AW(8)) serial_port_dma_channel_inst (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxFullFlag(rxFullFlag),
    .txEmptyFlag(txEmptyFlag), .rxData(rxData), .rxRead(rxRead),
    .txWrite(txWrite), .txData(txData),
    .channelPriority(channelPriority), .irq(irq));
  serial_port_model serial_port_model_inst (
    .clk(clk), .rstn(rstn), .loadRx(loadRx), .loadWord(loadWord),
    .shiftTx(shiftTx), .rxRead(rxRead), .txWrite(txWrite),
    .rxFullFlag(rxFullFlag), .txEmptyFlag(txEmptyFlag), .rxData(rxData));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // Enable, irq enable, mode 1, priority 1, no continuous, no 3-D
  function automatic logic [31:0] cw(logic [4:0] rq, logic [2:0] dm, sm,
                                     logic [1:0] ds, ss);
    return {8'h0, 2'b11, 3'h1, 2'h1, 1'b0, rq, 1'b0, dm, sm, ds, ss};
  endfunction : cw
  task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk({31'h0, pready}, 32'h1, "no ready");
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rdat, e, m);
  endtask : rchk
  task automatic xfer(input int p, input logic tx, input [23:0] w,
                      input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    if (tx) shiftTx[p] <= 1'b1;
    else loadRx[p] <= 1'b1;
    loadWord <= w;
    @(posedge clk);
    shiftTx <= 2'h0;
    loadRx <= 2'h0;
    for (int n = 0; n < 12 && !seen; n++) begin
      @(posedge clk);
      seen = tx ? txWrite[p] === 1'b1 : rxRead[p] === 1'b1;
    end
    chk({31'h0, seen}, {31'h0, exp}, "word moved");
    if (tx && seen) chk({8'h0, txData}, {8'h0, w}, "tx word");
  endtask : xfer
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 6; i++) rchk(8'(4 * i), 32'h0, "reset");
    rchk(8'h20, 32'h0, "unmapped");
    chk({31'h0, perr}, 32'h1, "unmapped err");
    apb(1'b1, CTRL_OFS, 32'hff7fffff);
    rchk(CTRL_OFS, 32'h007fffff, "ctrl rw");
    chk({30'h0, channelPriority}, 32'h3, "priority");
    chk({31'h0, irq}, 32'h0, "idle irq");
    apb(1'b1, CTRL_OFS, 32'h0);
  endtask : t_reset
  task automatic t_rx(input int p, input [4:0] rq, input [1:0] sp,
                      input [23:0] w0, w1, input logic m);
    apb(1'b1, SRC_OFS, 32'h40);
    apb(1'b1, DST_OFS, 32'h10);
    apb(1'b1, CNT_OFS, 32'h1);
    apb(1'b1, MASK_OFS, {31'h0, m});
    apb(1'b1, CTRL_OFS, cw(rq, AM_INC, AM_HOLD, sp, SPACE_X));
    chk({30'h0, channelPriority}, 32'h1, "priority");
    xfer(p, 1'b0, w0, 1'b1);
    xfer(p, 1'b0, w1, 1'b1);
    xfer(p, 1'b0, 24'h0, 1'b0);
    rchk(CTRL_OFS, cw(rq, AM_INC, AM_HOLD, sp, 2'h0) & 32'h7fffff,
         "self disable");
    rchk(DST_OFS, 32'h12, "dst inc");
    rchk(SRC_OFS, 32'h40, "src hold");
    chk({31'h0, irq}, {31'h0, m}, "irq");
    rchk(STATUS_OFS, 32'h3, "status");
    chk({31'h0, irq}, 32'h0, "irq cleared");
  endtask : t_rx
  task automatic t_tx(input int p, input [4:0] rq, input [1:0] sp,
                      input [23:0] w0, w1);
    apb(1'b1, SRC_OFS, 32'h10);
    apb(1'b1, DST_OFS, 32'h30);
    apb(1'b1, CNT_OFS, 32'h1);
    apb(1'b1, CTRL_OFS, cw(rq, AM_HOLD, AM_INC, SPACE_X, sp));
    xfer(p, 1'b1, w0, 1'b1);
    xfer(p, 1'b1, w1, 1'b1);
    xfer(p, 1'b1, 24'h0, 1'b0);
    rchk(SRC_OFS, 32'h12, "src inc");
    rchk(DST_OFS, 32'h30, "dst hold");
    rchk(CTRL_OFS, cw(rq, AM_HOLD, AM_INC, 2'h0, sp) & 32'h7fffff,
         "self disable");
  endtask : t_tx
  task automatic t_cont(input [23:0] w);
    logic [31:0] c;
    c = cw(REQ_P0_RX, AM_HOLD, AM_HOLD, SPACE_Y, SPACE_X) | 32'h10000;
    apb(1'b1, DST_OFS, 32'h20);
    apb(1'b1, CNT_OFS, 32'h0);
    apb(1'b1, MASK_OFS, 32'h2);
    // Word left pending on port 0 moves as soon as enabled
    apb(1'b1, CTRL_OFS, c);
    rchk(CTRL_OFS, c, "continuous keeps enable");
    chk({31'h0, irq}, 32'h1, "word irq");
    rchk(STATUS_OFS, 32'h3, "cont status");
    chk({31'h0, irq}, 32'h0, "word irq cleared");
    xfer(0, 1'b0, w, 1'b1);
    rchk(DST_OFS, 32'h20, "cont dst hold");
    apb(1'b1, CTRL_OFS, 32'h0);
  endtask : t_cont
  //////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {loadRx, shiftTx, loadWord} = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_rx(0, REQ_P0_RX, SPACE_X, 24'h111111, 24'h222222, 1'b1);
    t_rx(1, REQ_P1_RX, SPACE_Y, 24'h333333, 24'h444444, 1'b0);
    t_tx(0, REQ_P0_TX, SPACE_X, 24'h111111, 24'h222222);
    t_tx(1, REQ_P1_TX, SPACE_Y, 24'h333333, 24'h444444);
    t_cont(24'h555555);
    conclude();
  end
  // Whole run takes under 2000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule : serial_port_dma_channel_test
